// ===== stm_mailbox.sv
// Overview of operation
// - mailbox is four words, host-visible and writable
// - self-test searches for either key, classifies it
// - normal key at expected place and tests pass: check boot flags
// - diagnostic key turns mailbox into byte console
// - console polls found location, no interrupts
// - console uses no other flags or timers
// - console touches only the four mailbox words
// - word 0 low byte: host to processor data
// - word 1 bit 0: host byte waiting
// - word 2 low byte: processor to host data
// - word 3 bit 0: processor byte waiting
// - key not at expected place: search everywhere
// - status word: not used, error, passed
// - nothing found: error 22h, error status, stop
// - diagnostic key misplaced: error 21h, still console
`timescale 1ns/10ps
`default_nettype none
module stm_mailbox #(
    parameter int MEM_WORDS   = stm_pkg::MEM_WORDS_DEF,
    parameter int MBOX_BASE   = stm_pkg::MBOX_BASE_DEF,
    parameter int STATUS_ADDR = stm_pkg::STATUS_ADDR_DEF,
    parameter int LOAD_DEV_W  = stm_pkg::LOAD_DEV_W_DEF,
    parameter int FIFO_DEPTH  = stm_pkg::FIFO_DEPTH_DEF,
    parameter int AW          = $clog2(MEM_WORDS)
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  start_i,
    input  wire logic                  selftests_ok_i,
    input  wire logic                  auto_boot_i,
    input  wire logic [LOAD_DEV_W-1:0] auto_load_device_flag_i,
    input  wire logic                  host_we_i,
    input  wire logic [AW-1:0]         host_addr_i,
    input  wire logic [15:0]           host_wdata_i,
    output logic      [15:0]           host_rdata_o,
    output logic                       boot_start_o,
    output logic      [LOAD_DEV_W-1:0] boot_device_o,
    output logic                       stopped_o,
    output logic                       console_o,
    output logic      [7:0]            selftest_error_byte_o,
    input  wire logic                  tx_valid_i,
    input  wire logic [7:0]            tx_data_i,
    output logic                       transmit_holder_free_o,
    output logic                       receive_holder_full_o,
    output logic      [7:0]            rx_data_o,
    input  wire logic                  rx_ready_i
);
    localparam logic [AW-1:0] LAST_BASE = AW'(MEM_WORDS - stm_pkg::MBOX_WORDS);
    localparam logic [AW-1:0] EXP_BASE  = AW'(MBOX_BASE);
    localparam logic [AW-1:0] STS_ADDR  = AW'(STATUS_ADDR);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [MEM_WORDS-1:0][15:0] mem;
        stm_pkg::stm_state_t        state;
        stm_pkg::stm_hit_t          hit;
        logic                       at_exp;
        logic [AW-1:0]              addr;
        logic [AW-1:0]              base;
        logic [15:0]                rdata;
        logic                       boot_start;
        logic [LOAD_DEV_W-1:0]      boot_dev;
        logic                       stopped;
        logic                       console;
        logic [7:0]                 err;
        logic [7:0]                 tx_hold;
        logic                       tx_full;
        logic                       tx_stage;
        logic                       tx_free;
    } stm_mbox_st_t;

    stm_mbox_st_t r;
    stm_mbox_st_t next_r;
    logic         rx_push;
    stm_pkg::stm_hit_t exp_hit;
    stm_pkg::stm_hit_t scan_hit;

    stm_stream_if #(.W(stm_pkg::BYTE_W)) rx_in_s ();
    stm_stream_if #(.W(stm_pkg::BYTE_W)) rx_out_s ();

    function automatic logic [AW-1:0] wa(input logic [AW-1:0] b, input int k);
        wa = AW'(b + AW'(k));
    endfunction

    function automatic stm_pkg::stm_hit_t classify(input logic [MEM_WORDS-1:0][15:0] m,
                                                    input logic [AW-1:0] b);
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [15:0] w3;
        w0 = m[wa(b, 0)];
        w1 = m[wa(b, 1)];
        w2 = m[wa(b, 2)];
        w3 = m[wa(b, 3)];
        if (w0 == stm_pkg::KEY_NORMAL_0 && w1 == stm_pkg::KEY_NORMAL_1 &&
            w2 == stm_pkg::KEY_NORMAL_2 && w3 == stm_pkg::KEY_NORMAL_3)
        begin
            classify = stm_pkg::HIT_NORMAL;
        end
        else if (w0 == stm_pkg::KEY_DIAG_0 && w1 == stm_pkg::KEY_DIAG_1 &&
                 w2 == stm_pkg::KEY_DIAG_2 && w3 == stm_pkg::KEY_DIAG_3)
        begin
            classify = stm_pkg::HIT_DIAG;
        end
        else
        begin
            classify = stm_pkg::HIT_NONE;
        end
    endfunction

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    always_comb
    begin
        next_r   = r;
        rx_push  = 1'b0;
        exp_hit  = classify(r.mem, EXP_BASE);
        scan_hit = classify(r.mem, r.addr);
        next_r.rdata = r.mem[host_addr_i];
        // the host wins a shared cycle; device writes simply retry
        if (host_we_i)
        begin
            next_r.mem[host_addr_i] = host_wdata_i;
        end
        case (r.state)
            stm_pkg::S_IDLE:
            begin
                if (start_i)
                begin
                    next_r.state = stm_pkg::S_EXPECT;
                end
            end
            stm_pkg::S_EXPECT:
            begin
                if (exp_hit != stm_pkg::HIT_NONE)
                begin
                    next_r.hit    = exp_hit;
                    next_r.at_exp = 1'b1;
                    next_r.base   = EXP_BASE;
                    next_r.state  = stm_pkg::S_REPORT;
                end
                else
                begin
                    next_r.addr  = '0;
                    next_r.state = stm_pkg::S_SCAN;
                end
            end
            stm_pkg::S_SCAN:
            begin
                if (scan_hit != stm_pkg::HIT_NONE)
                begin
                    next_r.hit    = scan_hit;
                    next_r.at_exp = 1'b0;
                    next_r.base   = r.addr;
                    next_r.state  = stm_pkg::S_REPORT;
                end
                else if (r.addr == LAST_BASE)
                begin
                    next_r.hit   = stm_pkg::HIT_NONE;
                    next_r.state = stm_pkg::S_REPORT;
                end
                else
                begin
                    next_r.addr = AW'(r.addr + 1'b1);
                end
            end
            stm_pkg::S_REPORT:
            begin
                // status write is a device write, so it waits out the host
                if (!host_we_i)
                begin
                    next_r.mem[STS_ADDR] = stm_pkg::STS_ERROR;
                    case (r.hit)
                        stm_pkg::HIT_NONE:
                        begin
                            next_r.err     = stm_pkg::ERR_NOT_FOUND;
                            next_r.stopped = 1'b1;
                            next_r.state   = stm_pkg::S_DONE;
                        end
                        stm_pkg::HIT_NORMAL:
                        begin
                            if (!r.at_exp)
                            begin
                                next_r.err     = stm_pkg::ERR_NORMAL_WRONG;
                                next_r.stopped = 1'b1;
                            end
                            else if (selftests_ok_i)
                            begin
                                next_r.mem[STS_ADDR] = stm_pkg::STS_PASSED;
                                next_r.boot_start = auto_boot_i;
                                next_r.boot_dev   = auto_load_device_flag_i;
                            end
                            else
                            begin
                                next_r.stopped = 1'b1;
                            end
                            next_r.state = stm_pkg::S_DONE;
                        end
                        stm_pkg::HIT_DIAG:
                        begin
                            if (r.at_exp)
                            begin
                                next_r.mem[STS_ADDR] = stm_pkg::STS_PASSED;
                            end
                            else
                            begin
                                next_r.err = stm_pkg::ERR_DIAG_WRONG;
                            end
                            next_r.console = 1'b1;
                            next_r.tx_free = 1'b1;
                            next_r.state   = stm_pkg::S_POLL;
                        end
                        default:
                        begin
                            next_r.state = stm_pkg::S_DONE;
                        end
                    endcase
                end
            end
            stm_pkg::S_POLL:
            begin
                // plain polling of the found image, no interrupt or timer use
                if (r.tx_free && tx_valid_i)
                begin
                    next_r.tx_hold = tx_data_i;
                    next_r.tx_full = 1'b1;
                end
                if (!host_we_i)
                begin
                    if (r.mem[wa(r.base, stm_pkg::OFS_H2C_FLAG)][0] && rx_in_s.ready)
                    begin
                        rx_push = 1'b1;
                        next_r.mem[wa(r.base, stm_pkg::OFS_H2C_FLAG)] = 16'h0000;
                    end
                    if (r.tx_stage)
                    begin
                        next_r.mem[wa(r.base, stm_pkg::OFS_C2H_FLAG)] = 16'h0001;
                        next_r.tx_stage = 1'b0;
                        next_r.tx_full  = 1'b0;
                    end
                    else if (r.tx_full && !r.mem[wa(r.base, stm_pkg::OFS_C2H_FLAG)][0])
                    begin
                        // data lands a cycle before the flag; upper byte zero
                        next_r.mem[wa(r.base, stm_pkg::OFS_C2H_DATA)] =
                            {8'h00, r.tx_hold};
                        next_r.tx_stage = 1'b1;
                    end
                end
                next_r.tx_free = !next_r.tx_full;
            end
            stm_pkg::S_DONE:
            begin
                next_r.state = stm_pkg::S_DONE;
            end
            default:
            begin
                next_r.state = stm_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // -----------------------------------------------------------------
    // receive buffer towards the console user
    // -----------------------------------------------------------------
    assign rx_in_s.valid = rx_push;
    assign rx_in_s.data  = r.mem[wa(r.base, stm_pkg::OFS_H2C_DATA)][7:0];
    assign rx_out_s.ready = rx_ready_i;

    stm_fifo #(
        .WIDTH (stm_pkg::BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .wr_s      (rx_in_s),
        .rd_s      (rx_out_s)
    );

    assign host_rdata_o           = r.rdata;
    assign boot_start_o           = r.boot_start;
    assign boot_device_o          = r.boot_dev;
    assign stopped_o              = r.stopped;
    assign console_o              = r.console;
    assign selftest_error_byte_o  = r.err;
    assign transmit_holder_free_o = r.tx_free;
    assign receive_holder_full_o  = rx_out_s.valid;
    assign rx_data_o              = rx_out_s.data;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    host_read_a: assert property (
        1'b1 |=> host_rdata_o == $past(r.mem[host_addr_i])
            && (!$past(host_we_i) || r.mem[$past(host_addr_i)] == $past(host_wdata_i)))
        else $error("host read returned wrong word");
    expect_first_a: assert property (
        r.state == stm_pkg::S_EXPECT && exp_hit == stm_pkg::HIT_NONE
        |=> r.state == stm_pkg::S_SCAN && r.addr == '0)
        else $error("scan did not start at zero");
    scan_bound_a: assert property (
        r.state == stm_pkg::S_SCAN |-> r.addr <= LAST_BASE)
        else $error("scan ran past memory");
    miss_stop_a: assert property (
        r.state == stm_pkg::S_REPORT && r.hit == stm_pkg::HIT_NONE && !host_we_i
        |=> stopped_o && selftest_error_byte_o == stm_pkg::ERR_NOT_FOUND
            && r.mem[STS_ADDR] == stm_pkg::STS_ERROR)
        else $error("missing key not reported");
    diag_wrong_a: assert property (
        r.state == stm_pkg::S_REPORT && r.hit == stm_pkg::HIT_DIAG && !r.at_exp
        && !host_we_i |=> console_o && !stopped_o
            && selftest_error_byte_o == stm_pkg::ERR_DIAG_WRONG)
        else $error("misplaced diagnostic key not handled");
    boot_choice_a: assert property (
        r.state == stm_pkg::S_REPORT && r.hit == stm_pkg::HIT_NORMAL && r.at_exp
        && selftests_ok_i && !host_we_i
        |=> boot_start_o == $past(auto_boot_i)
            && r.mem[STS_ADDR] == stm_pkg::STS_PASSED)
        else $error("boot decision wrong");
    rx_release_a: assert property (
        rx_push ##1 !host_we_i |-> !r.mem[wa(r.base, stm_pkg::OFS_H2C_FLAG)][0]
            ##1 receive_holder_full_o)
        else $error("receive slot not released");
    tx_order_a: assert property (
        r.state == stm_pkg::S_POLL && !r.tx_stage && r.tx_full && !host_we_i
        && !r.mem[wa(r.base, stm_pkg::OFS_C2H_FLAG)][0]
        |=> r.mem[wa(r.base, stm_pkg::OFS_C2H_DATA)][7:0] == $past(r.tx_hold)
            && !r.mem[wa(r.base, stm_pkg::OFS_C2H_FLAG)][0])
        else $error("transmit flag rose before data");

    normal_boot_c: cover property (r.state == stm_pkg::S_REPORT
        && r.hit == stm_pkg::HIT_NORMAL ##1 boot_start_o);
    diag_console_c: cover property ($rose(console_o));
    not_found_c: cover property ($rose(stopped_o) && selftest_error_byte_o ==
        stm_pkg::ERR_NOT_FOUND);
    tx_sent_c: cover property (r.tx_stage ##1 !r.tx_full);
endmodule
`default_nettype wire

// ===== stm_pkg.sv
`default_nettype none
package stm_pkg;
    // -----------------------------------------------------------------
    // key patterns written by the host into the mailbox
    // -----------------------------------------------------------------
    localparam logic [15:0] KEY_NORMAL_0 = 16'hd1ae;
    localparam logic [15:0] KEY_NORMAL_1 = 16'he555;
    localparam logic [15:0] KEY_NORMAL_2 = 16'h4000;
    localparam logic [15:0] KEY_NORMAL_3 = 16'hc062;
    localparam logic [15:0] KEY_DIAG_0   = 16'hd1ae;
    localparam logic [15:0] KEY_DIAG_1   = 16'hc7ff;
    localparam logic [15:0] KEY_DIAG_2   = 16'hc062;
    localparam logic [15:0] KEY_DIAG_3   = 16'ha800;

    // -----------------------------------------------------------------
    // status word values and error codes
    // -----------------------------------------------------------------
    localparam logic [15:0] STS_NOT_USED = 16'h006c;
    localparam logic [15:0] STS_ERROR    = 16'h00b4;
    localparam logic [15:0] STS_PASSED   = 16'h00d8;
    localparam logic [7:0]  ERR_NONE     = 8'h00;
    localparam logic [7:0]  ERR_NORMAL_WRONG = 8'h20;
    localparam logic [7:0]  ERR_DIAG_WRONG   = 8'h21;
    localparam logic [7:0]  ERR_NOT_FOUND    = 8'h22;

    // -----------------------------------------------------------------
    // word offsets inside the mailbox and default placement
    // -----------------------------------------------------------------
    localparam int MBOX_WORDS       = 4;
    localparam int OFS_H2C_DATA     = 0;
    localparam int OFS_H2C_FLAG     = 1;
    localparam int OFS_C2H_DATA     = 2;
    localparam int OFS_C2H_FLAG     = 3;
    localparam int MEM_WORDS_DEF    = 64;
    localparam int MBOX_BASE_DEF    = 16;
    localparam int STATUS_ADDR_DEF  = 8;
    localparam int LOAD_DEV_W_DEF   = 4;
    localparam int FIFO_DEPTH_DEF   = 16;
    localparam int BYTE_W           = 8;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_EXPECT = 3'b001,
        S_SCAN   = 3'b010,
        S_REPORT = 3'b011,
        S_DONE   = 3'b100,
        S_POLL   = 3'b101
    } stm_state_t;

    typedef enum logic [1:0] {
        HIT_NONE   = 2'b00,
        HIT_NORMAL = 2'b01,
        HIT_DIAG   = 2'b10
    } stm_hit_t;
endpackage
`default_nettype wire

// ===== stm_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface stm_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== stm_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module stm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic   ref_clk_i,
    input  wire logic   arst_n_i,
    stm_stream_if.snk   wr_s,
    stm_stream_if.src   rd_s
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        vld;
    } stm_fifo_st_t;

    stm_fifo_st_t r;
    stm_fifo_st_t next_r;
    logic         push;
    logic         pop;

    always_comb
    begin
        next_r = r;
        push   = wr_s.valid && !r.full;
        pop    = r.vld && rd_s.ready;
        if (push)
        begin
            next_r.mem[r.wp] = wr_s.data;
            next_r.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : PW'(r.wp + 1'b1);
        end
        if (pop)
        begin
            next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : PW'(r.rp + 1'b1);
        end
        if (push && !pop)
        begin
            next_r.cnt = CW'(r.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            next_r.cnt = CW'(r.cnt - 1'b1);
        end
        next_r.full = (next_r.cnt == CW'(DEPTH));
        next_r.vld  = (next_r.cnt != '0);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign wr_s.ready = !r.full;
    assign rd_s.valid = r.vld;
    assign rd_s.data  = r.mem[r.rp];

    fifo_count_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        push && !pop |=> r.cnt == $past(r.cnt) + 1'b1)
        else $error("fifo count did not follow a push");
endmodule
`default_nettype wire

// ===== stm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// host side of the shared memory window
// ---------------------------------------------
module stm_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             we_o,
    output logic [5:0]       addr_o,
    output logic [15:0]      wdata_o
);
    initial
    begin
        we_o    = 1'b0;
        addr_o  = 6'h00;
        wdata_o = 16'h0000;
    end
    // data turns to junk once taken, so a late sample cannot match
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        we_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge ref_clk_i);
        we_o    <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        @(posedge ref_clk_i);
        #1 d = rdata_i;
    endtask
    task automatic put_key(input logic [5:0] base, input logic [63:0] k);
        int i;
        for (i = 0; i < 4; i++)
            wr(base + 6'(i), k[63 - 16 * i -: 16]);
    endtask
    // upper bits carry junk on purpose; data goes before the flag
    task automatic send(input logic [5:0] base, input logic [7:0] b);
        wr(base, {8'hff, b});
        wr(base + 6'h01, 16'hfff1);
    endtask
endmodule
`default_nettype wire

// ===== stm_mailbox_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------
// self-test search and console channel bench
// ---------------------------------------------
module stm_mailbox_tb_top;
    logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, ok = 1'b0, txv = 1'b0, rxr = 1'b0;
    logic [7:0] txd = 8'h00, err, rxd;
    logic [3:0] dev;
    logic ab = 1'b1;
    logic [15:0] rdata, w;
    logic we, boot, stop, con, free, full;
    logic [5:0] addr;
    logic [15:0] wdata;
    int n_fail = 0, checked = 0;
    localparam logic [63:0] KN = 64'hd1ae_e555_4000_c062;
    localparam logic [63:0] KD = 64'hd1ae_c7ff_c062_a800;
    always #25 clk = ~clk;
    stm_mailbox u_stm_mailbox (.ref_clk_i(clk), .arst_n_i(arst_n), .start_i(start),
        .selftests_ok_i(ok), .auto_boot_i(ab), .auto_load_device_flag_i(4'h9),
        .host_we_i(we), .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .boot_start_o(boot), .boot_device_o(dev), .stopped_o(stop), .console_o(con),
        .selftest_error_byte_o(err), .tx_valid_i(txv), .tx_data_i(txd),
        .transmit_holder_free_o(free), .receive_holder_full_o(full), .rx_data_o(rxd),
        .rx_ready_i(rxr));
    stm_host_model u_stm_host_model (.ref_clk_i(clk), .rdata_i(rdata), .we_o(we),
        .addr_o(addr), .wdata_o(wdata));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic poll(input logic [5:0] a, input logic v);
        int i;
        w = {16{~v}};
        for (i = 0; i < 40 && w[0] !== v; i++)
            u_stm_host_model.rd(a, w);
    endtask
    task automatic wait_full;
        int i;
        for (i = 0; i < 20 && full !== 1'b1; i++)
            @(posedge clk);
        #1;
    endtask
    task automatic pop;
        @(posedge clk);
        rxr <= 1'b1;
        @(posedge clk);
        rxr <= 1'b0;
        #1;
    endtask
    // the diagnostic key leaves word 1 bit 0 set, so the low byte of its word 0 comes first
    task automatic drain_key;
        wait_full;
        chk({8'h00, rxd}, {8'h00, KD[55:48]});
        pop;
    endtask
    task automatic offer(input logic [7:0] b);
        @(posedge clk);
        txv <= 1'b1;
        txd <= b;
        @(posedge clk);
        txv <= 1'b0;
    endtask
    // reset, optional key, search, then the sticky outcome
    task automatic outcome(input logic [63:0] k, input logic [5:0] b, input logic o,
                           input logic [15:0] st, input logic [7:0] e, input logic [2:0] f);
        int i;
        @(posedge clk);
        arst_n <= 1'b0;
        ok     <= o;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        u_stm_host_model.wr(6'd8, 16'h006c);
        if (k != 64'h0)
            u_stm_host_model.put_key(b, k);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        w = 16'h006c;
        for (i = 0; i < 100 && w === 16'h006c; i++)
            u_stm_host_model.rd(6'd8, w);
        chk(w, st);
        chk({8'h00, err}, {8'h00, e});
        chk({13'h0, con, stop, boot}, {13'h0, f});
    endtask
    task automatic t_normal;
        outcome(KN, 6'd16, 1'b1, 16'h00d8, 8'h00, 3'b001);
        chk({12'h0, dev}, 16'h0009);
        outcome(KN, 6'd16, 1'b0, 16'h00b4, 8'h00, 3'b010);
        outcome(KN, 6'd40, 1'b1, 16'h00b4, 8'h20, 3'b010);
        outcome(64'h0, 6'd0, 1'b1, 16'h00b4, 8'h22, 3'b010);
        @(posedge clk);
        ab <= 1'b0;
        outcome(KN, 6'd16, 1'b1, 16'h00d8, 8'h00, 3'b000);
    endtask
    task automatic t_diag_wrong;
        outcome(KD, 6'd40, 1'b1, 16'h00b4, 8'h21, 3'b100);
        drain_key;
        u_stm_host_model.send(6'd40, 8'h81);
        wait_full;
        chk({8'h00, rxd}, 16'h0081);
        pop;
    endtask
    task automatic t_console;
        int i;
        outcome(KD, 6'd16, 1'b1, 16'h00d8, 8'h00, 3'b100);
        drain_key;
        offer(8'ha5);
        poll(6'd19, 1'b1);
        u_stm_host_model.rd(6'd18, w);
        chk(w, 16'h00a5);
        offer(8'h3c);
        repeat (6) @(posedge clk);
        chk({15'h0, free}, 16'h0000);
        u_stm_host_model.rd(6'd18, w);
        chk(w, 16'h00a5);
        u_stm_host_model.wr(6'd19, 16'h0000);
        poll(6'd19, 1'b1);
        u_stm_host_model.rd(6'd18, w);
        chk(w, 16'h003c);
        chk({15'h0, free}, 16'h0001);
        // seventeen bytes: the last must wait for room in the holder
        for (i = 0; i < 17; i++)
        begin
            u_stm_host_model.send(6'd16, 8'(i));
            poll(6'd17, 1'b0);
        end
        chk(w, 16'hfff1);
        for (i = 0; i < 17; i++)
        begin
            wait_full;
            chk({8'h00, rxd}, 16'(i));
            pop;
        end
        repeat (4) @(posedge clk);
        chk({15'h0, full}, 16'h0000);
        u_stm_host_model.rd(6'd17, w);
        chk(w, 16'h0000);
    endtask
    initial
    begin
        t_console;
        t_diag_wrong;
        t_normal;
        report_and_stop;
    end
    initial
    begin
        #2000000;
        n_fail++;
        report_and_stop;
    end
endmodule
`default_nettype wire
